/* File: rmt_xfer_unit.sv */
`timescale 1ns/1ps
`include "rmt_defines.svh"
// Transfer and store datapath with its memory sequencer
module rmt_xfer_unit (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire rmt_pkg::rmt_op_e i_op,
   input wire logic [`RMT_SEL_W-1:0] i_src_sel,
   input wire logic [`RMT_SEL_W-1:0] i_dst_sel,
   input wire logic [1:0] i_short_sel,
   input wire logic [`RMT_W-1:0] i_operand,
   input wire logic i_ext_mode,
   input wire logic [`RMT_W-1:0] i_pc,
   input wire logic [`RMT_W-1:0] i_switches,
   input wire logic [`RMT_W-1:0] i_ea_base,
   input wire logic [`RMT_W-1:0] i_index,
   input wire logic i_indirect,
   input wire logic i_mem_ack,
   input wire logic [`RMT_W-1:0] i_mem_rdata,
   output logic o_busy,
   output logic o_done,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [`RMT_W-1:0] o_mem_addr,
   output logic [`RMT_W-1:0] o_mem_wdata,
   output logic o_mem_lock,
   output logic o_dma_inhibit,
   output logic o_int_block,
   output logic [`RMT_W-1:0] o_reg_i,
   output logic [`RMT_W-1:0] o_reg_j,
   output logic [`RMT_W-1:0] o_reg_k,
   output logic [`RMT_W-1:0] o_reg_e,
   output logic [`RMT_W-1:0] o_reg_a,
   output logic [`RMT_W-1:0] o_reg_t,
   output logic [3:0] o_cond
);
   import rmt_pkg::*;

   // Sequencer state
   rmt_state_e state_q;
   rmt_state_e state_d;
   // Latched instruction fields
   rmt_op_e op_q;
   logic [`RMT_SEL_W-1:0] src_q;
   logic [`RMT_SEL_W-1:0] dst_q;
   logic [1:0] short_q;
   logic [`RMT_W-1:0] opnd_q;
   logic ext_q;
   logic [`RMT_W-1:0] pc_q;
   // Memory word pointer and word counter
   logic [`RMT_W-1:0] addr_q;
   logic [`RMT_CNT_W-1:0] cnt_q;
   logic [`RMT_CNT_W-1:0] cnt_d;
   logic [`RMT_CNT_W-1:0] last_c;
   // Word read back from memory
   logic [`RMT_W-1:0] rd_q;
   logic [`RMT_W-1:0] rd_d;
   // Registered write data
   logic [`RMT_W-1:0] wdata_q;
   logic [`RMT_W-1:0] wdata_c;
   // General registers and condition flags
   rmt_regs_t regs_q;
   logic [3:0] cond_q;
   // Switch pins through two flops
   logic [`RMT_W-1:0] sw_meta_q;
   logic [`RMT_W-1:0] sw_q;
   // Lock, interrupt block and done pulse
   logic lock_q;
   logic int_block_q;
   logic done_q;
   // Commit decode
   logic commit_en;
   logic [`RMT_SEL_W-1:0] commit_mask;
   logic [`RMT_W-1:0] commit_val;
   logic byte_wr;
   logic cond_wr;
   logic cond_byte;
   logic ovf_wr;
   logic ovf_val;
   logic [`RMT_W-1:0] cond_src;
   // Shared helpers
   logic [`RMT_W-1:0] src_or;
   logic cc_pos;
   logic cc_neg;
   logic cc_zero;
   logic [`RMT_BYTE_W:0] sum9;
   logic [`RMT_BYTE_W-1:0] sum7;
   logic word_ack;
   logic fill_op;

   // OR of the selected sources
   rmt_sel_or u_src_or (
      .i_regs(regs_q),
      .i_sel(src_q),
      .o_val(src_or)
   );

   // Flag generator for the committed value, or for the word a fill reads
   rmt_cond_gen u_cond (
      .i_val(cond_src),
      .i_byte(cond_byte),
      .o_pos(cc_pos),
      .o_neg(cc_neg),
      .o_zero(cc_zero)
   );

   // Switch panel is asynchronous to the core clock
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sw_meta_q <= '0;
         sw_q <= '0;
      end else begin
         sw_meta_q <= i_switches;
         sw_q <= sw_meta_q;
      end
   end

   // Both fill operations need the atomic lock
   assign fill_op = (op_q == RMT_OP_FILL1) || (op_q == RMT_OP_FILL0);
   assign word_ack = i_mem_ack && o_mem_req;

   // Carries into and out of sign
   assign sum9 = {1'b0, regs_q[`RMT_IX_A][`RMT_BYTE_W-1:0]}
               + {1'b0, rd_q[`RMT_BYTE_W-1:0]};
   assign sum7 = {1'b0, regs_q[`RMT_IX_A][`RMT_BYTE_W-2:0]}
               + {1'b0, rd_q[`RMT_BYTE_W-2:0]};

   // Number of words each store emits, minus one
   always_comb begin
      case (op_q)
         RMT_OP_MSTORE: last_c = `RMT_LAST_FIVE;
         RMT_OP_DSTORE: last_c = `RMT_LAST_TWO;
         default: last_c = `RMT_LAST_ONE;
      endcase
   end

   // Next state of the memory sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         RMT_ST_IDLE: begin
            cnt_d = '0;
            if (i_start) begin
               case (i_op)
                  // Reads come first for these
                  RMT_OP_BSTORE, RMT_OP_FILL1, RMT_OP_FILL0, RMT_OP_ADDB: begin
                     state_d = RMT_ST_RD;
                  end
                  RMT_OP_DSTORE, RMT_OP_ASTORE, RMT_OP_ESTORE,
                  RMT_OP_ISTORE, RMT_OP_JSTORE, RMT_OP_MSTORE: begin
                     state_d = RMT_ST_WR;
                  end
                  // Register-only transfers
                  default: state_d = RMT_ST_FIN;
               endcase
            end
         end
         RMT_ST_RD: begin
            if (word_ack) begin
               state_d = (op_q == RMT_OP_ADDB) ? RMT_ST_FIN : RMT_ST_WR;
            end
         end
         RMT_ST_WR: begin
            if (word_ack) begin
               if (cnt_q == last_c) begin
                  state_d = RMT_ST_FIN;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         RMT_ST_FIN: state_d = RMT_ST_IDLE;
         default: state_d = RMT_ST_IDLE;
      endcase
   end

   // State and counter
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q <= RMT_ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Instruction fields held for the whole operation
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         op_q <= RMT_OP_SHORT;
         src_q <= '0;
         dst_q <= '0;
         short_q <= '0;
         opnd_q <= '0;
         ext_q <= 1'b0;
         pc_q <= '0;
      end else if (state_q == RMT_ST_IDLE && i_start) begin
         op_q <= i_op;
         src_q <= i_src_sel;
         dst_q <= i_dst_sel;
         short_q <= i_short_sel;
         opnd_q <= i_operand;
         ext_q <= i_ext_mode;
         pc_q <= i_pc;
      end
   end

   // Word pointer steps after each accepted write except the last one
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         addr_q <= '0;
      end else if (state_q == RMT_ST_IDLE && i_start) begin
         if ((i_op == RMT_OP_FILL1 || i_op == RMT_OP_FILL0) && !i_indirect) begin
            addr_q <= i_ea_base;
         end else begin
            addr_q <= i_ea_base + i_index;
         end
      end else if (state_q == RMT_ST_WR && word_ack && cnt_q != last_c) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // Captured read word, visible to the merge the same cycle
   assign rd_d = (state_q == RMT_ST_RD && word_ack) ? i_mem_rdata : rd_q;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

   // Next word's data; idle uses the op being taken, so the first word meets its request
   always_comb begin
      case ((state_q == RMT_ST_IDLE) ? i_op : op_q)
         // Index one, two, three, extension, main
         RMT_OP_MSTORE: wdata_c = regs_q[cnt_d];
         RMT_OP_DSTORE: begin
            wdata_c = (cnt_d == '0) ? regs_q[`RMT_IX_E] : regs_q[`RMT_IX_A];
         end
         RMT_OP_ASTORE: wdata_c = regs_q[`RMT_IX_A];
         RMT_OP_ESTORE: wdata_c = regs_q[`RMT_IX_E];
         RMT_OP_ISTORE: wdata_c = regs_q[`RMT_IX_I];
         RMT_OP_JSTORE: wdata_c = regs_q[`RMT_IX_J];
         RMT_OP_BSTORE: begin
            wdata_c = {rd_d[`RMT_W-1:`RMT_BYTE_W], regs_q[`RMT_IX_A][`RMT_BYTE_W-1:0]};
         end
         RMT_OP_FILL1: wdata_c = '1;
         RMT_OP_FILL0: wdata_c = '0;
         default: wdata_c = '0;
      endcase
   end

   // Write data comes from a flop, never straight from the mux
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wdata_q <= '0;
      end else begin
         wdata_q <= wdata_c;
      end
   end

   // Lock spans read and write of fills
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         lock_q <= 1'b0;
      end else if (state_q == RMT_ST_IDLE && i_start) begin
         lock_q <= (i_op == RMT_OP_FILL1) || (i_op == RMT_OP_FILL0);
      end else if (state_q == RMT_ST_FIN) begin
         lock_q <= 1'b0;
      end
   end

   // What the finishing cycle writes back
   always_comb begin
      commit_en = (state_q == RMT_ST_FIN);
      commit_mask = '0;
      commit_val = '0;
      byte_wr = 1'b0;
      cond_wr = 1'b0;
      cond_byte = 1'b0;
      ovf_wr = 1'b0;
      ovf_val = 1'b0;
      cond_src = '0;
      case (op_q)
         RMT_OP_SHORT: begin
            // Codes one to three pick I, J, K
            if (short_q != `RMT_SHORT_NONE) begin
               commit_mask[short_q - 1'b1] = 1'b1;
            end
            commit_val = {{(`RMT_W-`RMT_SHORT_W){1'b0}}, opnd_q[`RMT_SHORT_W-1:0]};
         end
         RMT_OP_LONG: begin
            commit_mask[`RMT_IX_K] = 1'b1;
            if (ext_q && !opnd_q[`RMT_LONG_ABS]) begin
               // Page bits from the program counter
               commit_val = {4'h0, pc_q[`RMT_PC_HI:`RMT_PC_LO],
                             opnd_q[`RMT_LONG_ABS-1:0]};
            end else begin
               commit_val = {{(`RMT_W-`RMT_LONG_W){1'b0}}, opnd_q[`RMT_LONG_W-1:0]};
            end
         end
         RMT_OP_EXT: begin
            commit_mask[`RMT_IX_K] = 1'b1;
            commit_val = opnd_q;
         end
         RMT_OP_SWITCH: begin
            commit_mask = dst_q;
            commit_val = sw_q;
            cond_wr = 1'b1;
            cond_src = sw_q;
         end
         RMT_OP_R2B: begin
            byte_wr = 1'b1;
            commit_val = src_or;
         end
         RMT_OP_R2R: begin
            commit_mask = dst_q;
            commit_val = src_or;
            cond_wr = 1'b1;
            cond_src = src_or;
         end
         RMT_OP_FILL1, RMT_OP_FILL0: begin
            cond_wr = 1'b1;
            cond_src = rd_q;
         end
         RMT_OP_ADDB: begin
            byte_wr = 1'b1;
            commit_val = {{(`RMT_W-`RMT_BYTE_W){1'b0}}, sum9[`RMT_BYTE_W-1:0]};
            cond_wr = 1'b1;
            cond_byte = 1'b1;
            cond_src = commit_val;
            ovf_wr = 1'b1;
            ovf_val = sum7[`RMT_BYTE_W-1] ^ sum9[`RMT_BYTE_W];
         end
         default: commit_mask = '0;
      endcase
   end

   // One process per general register
   genvar g;
   for (g = 0; g < `RMT_NREG; g = g + 1) begin : g_reg
      always_ff @(posedge i_clk) begin
         if (!i_nrst) begin
            regs_q[g] <= '0;
         end else if (commit_en && byte_wr && g == `RMT_IX_A) begin
            // Byte accumulator is main low byte
            regs_q[g][`RMT_BYTE_W-1:0] <= commit_val[`RMT_BYTE_W-1:0];
         end else if (commit_en && commit_mask[g]) begin
            regs_q[g] <= commit_val;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cond_q <= '0;
      end else if (commit_en && cond_wr) begin
         cond_q[`RMT_CC_P] <= cc_pos;
         cond_q[`RMT_CC_N] <= cc_neg;
         cond_q[`RMT_CC_Z] <= cc_zero;
         if (ovf_wr) begin
            cond_q[`RMT_CC_V] <= ovf_val;
         end
      end
   end

   // Hold off interrupts for one instruction
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         int_block_q <= 1'b0;
      end else if (commit_en) begin
         // A second multi store renews the block
         int_block_q <= (op_q == RMT_OP_MSTORE);
      end
   end

   // Completion pulse, one cycle after the commit
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= commit_en;
      end
   end

   // Outputs
   assign o_busy = (state_q != RMT_ST_IDLE);
   assign o_done = done_q;
   assign o_mem_req = (state_q == RMT_ST_RD) || (state_q == RMT_ST_WR);
   assign o_mem_we = (state_q == RMT_ST_WR);
   assign o_mem_addr = addr_q;
   assign o_mem_wdata = wdata_q;
   // DMA held off with the lock
   assign o_mem_lock = lock_q && fill_op;
   assign o_dma_inhibit = lock_q && fill_op;
   assign o_int_block = int_block_q;
   assign o_reg_i = regs_q[`RMT_IX_I];
   assign o_reg_j = regs_q[`RMT_IX_J];
   assign o_reg_k = regs_q[`RMT_IX_K];
   assign o_reg_e = regs_q[`RMT_IX_E];
   assign o_reg_a = regs_q[`RMT_IX_A];
   assign o_reg_t = regs_q[`RMT_IX_T];
   assign o_cond = cond_q;
endmodule

/* File: rmt_defines.svh */
`ifndef RMT_DEFINES_SVH
`define RMT_DEFINES_SVH

// Data path widths
`define RMT_W 24
`define RMT_SEL_W 6
`define RMT_NREG 6
`define RMT_BYTE_W 8
`define RMT_SHORT_W 15
`define RMT_LONG_W 16
// Register positions in one-hot selects
`define RMT_IX_I 0
`define RMT_IX_J 1
`define RMT_IX_K 2
`define RMT_IX_E 3
`define RMT_IX_A 4
`define RMT_IX_T 5
// Condition register bits
`define RMT_CC_V 0
`define RMT_CC_N 1
`define RMT_CC_Z 2
`define RMT_CC_P 3
// Long operand fields
`define RMT_LONG_ABS 15
`define RMT_PC_HI 19
`define RMT_PC_LO 15
// Store sequence lengths, last word index
`define RMT_LAST_ONE 3'h0
`define RMT_LAST_TWO 3'h1
`define RMT_LAST_FIVE 3'h4
`define RMT_CNT_W 3
`define RMT_SHORT_NONE 2'h0
`endif

/* File: rmt_pkg.sv */
package rmt_pkg;
   // Operation requested by the sequencer
   typedef enum logic [3:0] {
      RMT_OP_SHORT  = 4'h0,
      RMT_OP_LONG   = 4'h1,
      RMT_OP_EXT    = 4'h2,
      RMT_OP_SWITCH = 4'h3,
      RMT_OP_R2B    = 4'h4,
      RMT_OP_R2R    = 4'h5,
      RMT_OP_BSTORE = 4'h6,
      RMT_OP_DSTORE = 4'h7,
      RMT_OP_FILL1  = 4'h8,
      RMT_OP_FILL0  = 4'h9,
      RMT_OP_ASTORE = 4'hA,
      RMT_OP_ESTORE = 4'hB,
      RMT_OP_ISTORE = 4'hC,
      RMT_OP_JSTORE = 4'hD,
      RMT_OP_MSTORE = 4'hE,
      RMT_OP_ADDB   = 4'hF
   } rmt_op_e;
   // Sequencer states
   typedef enum logic [1:0] {
      RMT_ST_IDLE = 2'h0,
      RMT_ST_RD   = 2'h1,
      RMT_ST_WR   = 2'h2,
      RMT_ST_FIN  = 2'h3
   } rmt_state_e;
   // All six general registers side by side
   typedef logic [5:0][23:0] rmt_regs_t;
endpackage

/* File: rmt_sel_or.sv */
`timescale 1ns/1ps
`include "rmt_defines.svh"
// ORs every register whose one-hot select bit is set
module rmt_sel_or (
   input wire rmt_pkg::rmt_regs_t i_regs,
   input wire logic [`RMT_SEL_W-1:0] i_sel,
   output logic [`RMT_W-1:0] o_val
);
   import rmt_pkg::*;
   // Masked copies, one per register
   logic [`RMT_NREG-1:0][`RMT_W-1:0] masked;
   genvar g;
   for (g = 0; g < `RMT_NREG; g = g + 1) begin : g_mask
      assign masked[g] = i_sel[g] ? i_regs[g] : '0;
   end
   // No selection yields zero
   always_comb begin
      o_val = '0;
      for (int n = 0; n < `RMT_NREG; n++) begin
         o_val = o_val | masked[n];
      end
   end
endmodule

/* File: rmt_cond_gen.sv */
`timescale 1ns/1ps
`include "rmt_defines.svh"
// Positive, negative or zero of a word or of its low byte
module rmt_cond_gen (
   input wire logic [`RMT_W-1:0] i_val,
   input wire logic i_byte,
   output logic o_pos,
   output logic o_neg,
   output logic o_zero
);
   import rmt_pkg::*;
   // Sign and zero of the chosen width
   logic sign;
   logic zero;
   always_comb begin
      if (i_byte) begin
         sign = i_val[`RMT_BYTE_W-1];
         zero = (i_val[`RMT_BYTE_W-1:0] == '0);
      end else begin
         sign = i_val[`RMT_W-1];
         zero = (i_val == '0);
      end
      o_zero = zero;
      o_neg = sign;
      o_pos = !zero && !sign;
   end
endmodule

/* File: rmt_checker.sv */
`timescale 1ns/1ps
// Watches the transfer unit's ports for rule breaks
module rmt_checker (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire rmt_pkg::rmt_op_e i_op,
   input wire logic [23:0] i_ea_base,
   input wire logic [23:0] i_index,
   input wire logic i_indirect,
   input wire logic i_mem_ack,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [23:0] o_mem_addr,
   input wire logic [23:0] o_mem_wdata,
   input wire logic o_mem_lock,
   input wire logic o_dma_inhibit,
   input wire logic o_int_block,
   input wire logic [23:0] o_reg_i,
   input wire logic [23:0] o_reg_j,
   input wire logic [23:0] o_reg_k,
   input wire logic [23:0] o_reg_e,
   input wire logic [23:0] o_reg_a,
   input wire logic [3:0] o_cond
);
   import rmt_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   rmt_op_e op_q; // Instruction last taken
   logic [23:0] base_q; // Its address before the offset
   logic [23:0] a_q; // Main accumulator at start
   logic [3:0] c_q; // Condition at start
   logic fill;
   logic st;
   logic [23:0] off;
   assign fill = op_q inside {RMT_OP_FILL1, RMT_OP_FILL0};
   assign st = op_q inside {RMT_OP_DSTORE, [RMT_OP_ASTORE:RMT_OP_MSTORE]};
   assign off = o_mem_addr - base_q;
   // Snapshot at the accepting edge; fills skip direct indexing
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         op_q <= RMT_OP_SHORT;
         base_q <= 24'h0;
         a_q <= 24'h0;
         c_q <= 4'h0;
      end else if (i_start && !o_busy) begin
         op_q <= i_op;
         base_q <= i_ea_base + ((i_op inside {RMT_OP_FILL1, RMT_OP_FILL0} && !i_indirect) ?
            24'h0 : i_index);
         a_q <= o_reg_a;
         c_q <= o_cond;
      end
   end
   // Word a store must place at an offset; registers stand still meanwhile
   function automatic logic [23:0] exp_wd(logic [23:0] o);
      case (op_q)
         RMT_OP_ASTORE: return o_reg_a;
         RMT_OP_ESTORE: return o_reg_e;
         RMT_OP_ISTORE: return o_reg_i;
         RMT_OP_JSTORE: return o_reg_j;
         RMT_OP_DSTORE: return o[0] ? o_reg_a : o_reg_e;
         default: return o == 24'h0 ? o_reg_i : o == 24'h1 ? o_reg_j :
            o == 24'h2 ? o_reg_k : o == 24'h3 ? o_reg_e : o_reg_a;
      endcase
   endfunction
   a_fill_locked: assert property (fill && o_mem_req |-> o_mem_lock && o_dma_inhibit)
      else $error("fill access without lock");
   a_fill_rmw: assert property (fill && o_mem_req && !o_mem_we && i_mem_ack |->
      ##[1:40] (o_mem_req && o_mem_we && o_mem_lock)) else $error("fill write missing");
   a_fill_noindex: assert property (fill && o_mem_req |-> o_mem_addr == base_q)
      else $error("fill address wrong");
   a_fill_ones: assert property (op_q == RMT_OP_FILL1 && o_mem_req && o_mem_we |->
      o_mem_wdata == 24'hFFFFFF) else $error("fill ones data wrong");
   a_fill_zeros: assert property (op_q == RMT_OP_FILL0 && o_mem_req && o_mem_we |->
      o_mem_wdata == 24'h0) else $error("fill zeros data wrong");
   a_store_data: assert property (st && o_mem_req && o_mem_we |-> o_mem_wdata == exp_wd(off) &&
      off <= ((op_q == RMT_OP_MSTORE) ? 24'h4 : {23'h0, op_q == RMT_OP_DSTORE}))
      else $error("store word or address wrong");
   a_int_hold: assert property (o_done |-> o_int_block == (op_q == RMT_OP_MSTORE))
      else $error("interrupt hold-off wrong");
   a_cond_onehot: assert property (o_done && op_q inside {RMT_OP_SWITCH, RMT_OP_R2R,
      RMT_OP_FILL1, RMT_OP_FILL0, RMT_OP_ADDB} |-> $onehot(o_cond[3:1])) else $error("flags not one-hot");
   a_cond_kept: assert property (o_done |-> (op_q == RMT_OP_ADDB || o_cond[0] == c_q[0]) &&
      (op_q inside {RMT_OP_LONG, RMT_OP_SWITCH, RMT_OP_R2R, RMT_OP_FILL1, RMT_OP_FILL0,
      RMT_OP_ADDB} || o_cond == c_q)) else $error("condition changed");
   a_byte_upper: assert property (o_done && op_q inside {RMT_OP_R2B, RMT_OP_ADDB} |->
      o_reg_a[23:8] == a_q[23:8]) else $error("upper accumulator changed");
   c_fill_done: cover property (fill && o_done);
   c_multi_done: cover property (op_q == RMT_OP_MSTORE && o_done);
   c_add_ovf: cover property (op_q == RMT_OP_ADDB && o_done && o_cond[0]);
endmodule

/* File: rmt_mem_model.sv */
`timescale 1ns/1ps
// Word memory, prompt or randomly slow in answering
module rmt_mem_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [23:0] i_addr,
   input wire logic [23:0] i_wdata,
   output logic o_ack = 1'b0,
   output logic [23:0] o_rdata = 24'h0
);
   logic [23:0] mem [16]; // Low address bits only
   logic go; // Acknowledge this request now
   // sole master here
   // No second master competes, so a locked pair stays atomic
   always @(posedge i_clk) begin
      go = i_req && !o_ack && (!i_slow || $urandom_range(2) == 0);
      if (i_req && o_ack && i_we) mem[i_addr[3:0]] <= i_wdata;
      o_ack <= go;
      // Idle data toggles so stale values never pass as valid
      o_rdata <= go ? mem[i_addr[3:0]] : ~o_rdata;
   end
endmodule

/* File: rmt_xfer_unit_tb.sv */
`timescale 1ns/1ps
module rmt_xfer_unit_tb;
   import rmt_pkg::*;
   logic i_clk, i_nrst, i_start, i_ext_mode, i_indirect, slow, i_mem_ack;
   rmt_op_e i_op;
   logic [5:0] i_src_sel, i_dst_sel;
   logic [1:0] i_short_sel;
   logic [23:0] i_operand, i_pc, i_switches, i_ea_base, i_index, i_mem_rdata;
   logic o_busy, o_done, o_mem_req, o_mem_we, o_mem_lock, o_dma_inhibit, o_int_block;
   logic [23:0] o_mem_addr, o_mem_wdata;
   logic [3:0] o_cond;
   logic [23:0] dr [6]; // Registers seen at the ports
   logic [23:0] er [6]; // Registers expected
   logic [23:0] shm [16]; // Memory expected
   logic [3:0] ec; // Condition expected
   logic cok; // Sign flags known
   int fails, checks_done, i;
   rmt_xfer_unit dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start), .i_op(i_op),
      .i_src_sel(i_src_sel), .i_dst_sel(i_dst_sel), .i_short_sel(i_short_sel),
      .i_operand(i_operand), .i_ext_mode(i_ext_mode), .i_pc(i_pc), .i_switches(i_switches),
      .i_ea_base(i_ea_base), .i_index(i_index), .i_indirect(i_indirect), .i_mem_ack(i_mem_ack),
      .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done), .o_mem_req(o_mem_req),
      .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .o_mem_lock(o_mem_lock), .o_dma_inhibit(o_dma_inhibit), .o_int_block(o_int_block),
      .o_reg_i(dr[0]), .o_reg_j(dr[1]), .o_reg_k(dr[2]), .o_reg_e(dr[3]), .o_reg_a(dr[4]),
      .o_reg_t(dr[5]), .o_cond(o_cond));
   rmt_mem_model u_mem (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req), .i_we(o_mem_we),
      .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   // Free-running clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic cmp_word(logic [23:0] got, logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_cond(logic [3:0] got, logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test();
      if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // OR of the selected expected registers
   function automatic logic [23:0] orsel(logic [5:0] m);
      logic [23:0] v;
      v = 24'h0;
      for (int k = 0; k < 6; k++) if (m[k]) v |= er[k];
      return v;
   endfunction
   // Sign flags; overflow bit left alone
   task automatic setf(logic z, logic n);
      ec[3:1] = {!z && !n, z, n};
      cok = 1'b1;
   endtask
   // Expected effect of the instruction on the driven inputs
   task automatic predict();
      logic [23:0] a, v;
      logic [7:0] s;
      a = i_ea_base + ((i_op inside {RMT_OP_FILL1, RMT_OP_FILL0} && !i_indirect) ? 24'h0 : i_index);
      case (i_op)
         RMT_OP_SHORT: if (i_short_sel != 2'h0) er[i_short_sel - 2'h1] = {9'h0, i_operand[14:0]};
         RMT_OP_LONG: begin
            er[2] = (!i_ext_mode || i_operand[15]) ? {8'h0, i_operand[15:0]} :
               {4'h0, i_pc[19:15], i_operand[14:0]};
            cok = 1'b0;
         end
         RMT_OP_EXT: er[2] = i_operand;
         RMT_OP_SWITCH, RMT_OP_R2R: begin
            v = (i_op == RMT_OP_SWITCH) ? i_switches : orsel(i_src_sel);
            for (int k = 0; k < 6; k++) if (i_dst_sel[k]) er[k] = v;
            setf(v == 24'h0, v[23]);
         end
         RMT_OP_R2B: begin
            v = orsel(i_src_sel);
            er[4][7:0] = v[7:0];
         end
         RMT_OP_BSTORE: shm[a[3:0]][7:0] = er[4][7:0];
         RMT_OP_DSTORE: begin
            shm[a[3:0]] = er[3];
            shm[a[3:0] + 4'h1] = er[4];
         end
         RMT_OP_FILL1, RMT_OP_FILL0: begin
            v = shm[a[3:0]];
            setf(v == 24'h0, v[23]);
            shm[a[3:0]] = (i_op == RMT_OP_FILL1) ? 24'hFFFFFF : 24'h0;
         end
         RMT_OP_ASTORE: shm[a[3:0]] = er[4];
         RMT_OP_ESTORE: shm[a[3:0]] = er[3];
         RMT_OP_ISTORE: shm[a[3:0]] = er[0];
         RMT_OP_JSTORE: shm[a[3:0]] = er[1];
         RMT_OP_MSTORE: for (int k = 0; k < 5; k++) shm[a[3:0] + k] = er[k];
         default: begin
            s = er[4][7:0] + shm[a[3:0]][7:0];
            ec[0] = (er[4][7] == shm[a[3:0]][7]) && (s[7] != er[4][7]);
            er[4][7:0] = s;
            setf(s == 8'h0, s[7]);
         end
      endcase
   endtask
   // One instruction; switches settle through their synchroniser first
   task automatic run(rmt_op_e op, logic [5:0] s, logic [5:0] d, logic [23:0] opd,
      logic [23:0] ea, logic [23:0] ix, logic ex, logic ind);
      int n;
      @(posedge i_clk);
      i_op <= op;
      i_src_sel <= s;
      i_short_sel <= s[1:0];
      i_dst_sel <= d;
      i_operand <= opd;
      i_ea_base <= ea;
      i_index <= ix;
      i_ext_mode <= ex;
      i_indirect <= ind;
      i_switches <= 24'($urandom);
      i_pc <= 24'($urandom);
      repeat (3) @(posedge i_clk);
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_done !== 1'b1 && n < 60);
      cmp_word({22'h0, o_done, o_busy}, 24'h2);
      predict();
      for (int k = 0; k < 6; k++) cmp_word(dr[k], er[k]);
      if (cok) cmp_cond(o_cond, ec);
      for (int k = 0; k < 16; k++) cmp_word(u_mem.mem[k], shm[k]);
      cmp_word({23'h0, o_int_block}, {23'h0, op == RMT_OP_MSTORE});
   endtask
   initial begin
      rmt_op_e op;
      logic [5:0] s;
      void'($urandom(32'hB358ECA0));
      {i_nrst, i_start, i_ext_mode, i_indirect, slow} = 5'h0;
      i_op = RMT_OP_SHORT;
      {i_src_sel, i_dst_sel, i_short_sel} = 14'h0;
      {i_operand, i_pc, i_switches, i_ea_base, i_index} = 120'h0;
      {fails, checks_done, cok, ec} = {32'h0, 32'h0, 1'b1, 4'h0};
      for (i = 0; i < 6; i++) er[i] = 24'h0;
      for (i = 0; i < 16; i++) begin
         u_mem.mem[i] = 24'($urandom);
         shm[i] = u_mem.mem[i];
      end
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (i = 0; i < 4; i++) run(RMT_OP_SHORT, 6'(i), 6'h0, 24'hFFFFFF, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_LONG, 6'h0, 6'h0, 24'hFF8123, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_LONG, 6'h0, 6'h0, 24'hFF8123, 24'h0, 24'h0, 1'b1, 1'b0);
      run(RMT_OP_LONG, 6'h0, 6'h0, 24'hFF1234, 24'h0, 24'h0, 1'b1, 1'b0);
      run(RMT_OP_EXT, 6'h0, 6'h0, 24'hFEDCBA, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_SWITCH, 6'h0, 6'h18, 24'h0, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_SWITCH, 6'h0, 6'h00, 24'h0, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_SHORT, 6'h1, 6'h0, 24'h00007F, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_R2R, 6'h21, 6'h26, 24'h0, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_R2B, 6'h01, 6'h0, 24'h0, 24'h0, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_BSTORE, 6'h0, 6'h0, 24'h0, 24'h4, 24'h1, 1'b0, 1'b0);
      run(RMT_OP_ADDB, 6'h0, 6'h0, 24'h0, 24'h5, 24'h0, 1'b0, 1'b0);
      run(RMT_OP_FILL1, 6'h0, 6'h0, 24'h0, 24'h3, 24'h2, 1'b0, 1'b0);
      run(RMT_OP_FILL0, 6'h0, 6'h0, 24'h0, 24'h3, 24'h2, 1'b0, 1'b1);
      run(RMT_OP_DSTORE, 6'h0, 6'h0, 24'h0, 24'h8, 24'h1, 1'b0, 1'b0);
      for (i = 10; i < 14; i++) run(rmt_op_e'(i), 6'h0, 6'h0, 24'h0, 24'(i - 8), 24'h1, 1'b0, 1'b0);
      run(RMT_OP_MSTORE, 6'h0, 6'h0, 24'h0, 24'h9, 24'h2, 1'b0, 1'b0);
      slow = 1'b1;
      repeat (150) begin
         op = rmt_op_e'($urandom_range(15));
         s = 6'($urandom);
         if (op == RMT_OP_R2B) s &= 6'h2F;
         run(op, s, 6'($urandom), 24'($urandom), 24'($urandom_range(9)), 24'($urandom_range(2)),
            1'($urandom), 1'($urandom));
      end
      finish_test();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #1000000;
      cmp_word(24'h0, 24'h1);
      finish_test();
   end
endmodule
bind rmt_xfer_unit rmt_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start),
   .i_op(i_op), .i_ea_base(i_ea_base), .i_index(i_index), .i_indirect(i_indirect),
   .i_mem_ack(i_mem_ack), .o_busy(o_busy), .o_done(o_done), .o_mem_req(o_mem_req),
   .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
   .o_mem_lock(o_mem_lock), .o_dma_inhibit(o_dma_inhibit), .o_int_block(o_int_block),
   .o_reg_i(o_reg_i), .o_reg_j(o_reg_j), .o_reg_k(o_reg_k), .o_reg_e(o_reg_e),
   .o_reg_a(o_reg_a), .o_cond(o_cond));
